// ### hdl/jfpr_pkg.sv
// Overview of operation
// - code 0x7 selects 8-bit flash byte register
// - byte register is command register low bits
// - captures alternate low then high byte
// - address increments after every high byte
// - byte register shifts TDI to TDO
// - reset register one holds part reset
// - reset register bit acts without update latch
// - reset time-out follows clearing reset bit
// - 16-bit enable register compared with signature
// - programming enabled only on signature match
// - enable register clears at power-on reset
// - code 0x4 selects enable register, update checks
package jfpr_pkg;

  localparam int IR_W = 4;
  localparam logic [3:0] DIRECT_FLASH_BYTE_CAPTURE_INSTR = 4'h7;
  localparam logic [3:0] PROGRAMMING_UNLOCK_SELECT = 4'h4;
  localparam logic [3:0] RESET_REG_SELECT = 4'hC;
  localparam logic [3:0] BYPASS_INSTR = 4'hF;
  localparam logic [3:0] IR_CAPTURE_VAL = 4'h1;

  localparam int CMD_W = 15;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int ENABLE_W = 16;
  localparam logic [15:0] UNLOCK_SIGNATURE = 16'hA370;
  localparam logic [15:0] ENABLE_RST_VAL = 16'h0000;
  localparam logic [7:0] BLOCKED_BYTE = 8'h00;
  localparam logic [7:0] NOT_READY_BYTE = 8'hFF;
  localparam int ADDR_W_DEF = 13;

  // reset time-out choices, selected by the clock-option fuses
  localparam int CLK_PERIOD_NS = 20;
  localparam int TIMEOUT_A_US = 4000;
  localparam int TIMEOUT_B_US = 64000;
  localparam int TIMEOUT_A_CYC = (TIMEOUT_A_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_B_CYC = (TIMEOUT_B_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] TIMEOUT_MIN_CYC = 32'h0000_0001;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jfpr_tap_t;

  typedef enum logic [1:0] {FT_IDLE, FT_WAIT, FT_LATCH} jfpr_fetch_st_t;

endpackage

// ### hdl/jfpr_fetch_if.sv
interface jfpr_fetch_if;
  logic reqTgl;
  logic ackTgl;
  logic [15:0] word;
  modport tap (output reqTgl, input ackTgl, input word);
  modport fetch (input reqTgl, output ackTgl, output word);
endinterface

// ### hdl/jfpr_sync2.sv
module jfpr_sync2 #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  if (W < 1) begin : g_bad_width
    $error("jfpr_sync2: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } jfpr_sync_t;

  jfpr_sync_t st_r;
  jfpr_sync_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {(2 * W){RST_VAL}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule // jfpr_sync2

// ### hdl/jfpr_word_fetch.sv
module jfpr_word_fetch #(
  parameter int ADDR_W = jfpr_pkg::ADDR_W_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  jfpr_fetch_if.fetch lnk,
  input wire logic addrLoad,
  input wire logic [ADDR_W-1:0] addrPreset,
  output logic [ADDR_W-1:0] flashAddr,
  input wire logic [15:0] flashRdData
);
  if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr
    $error("jfpr_word_fetch: ADDR_W out of range");
  end

  typedef struct packed {
    jfpr_pkg::jfpr_fetch_st_t st;
    logic [ADDR_W-1:0] addr;
    logic [15:0] word;
    logic ack;
    logic reqSeen;
  } jfpr_fetch_t;

  jfpr_fetch_t f_r;
  jfpr_fetch_t f_nxt;
  logic reqSync;

  jfpr_sync2 #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(lnk.reqTgl),
    .q(reqSync)
  );

  always_comb begin
    f_nxt = f_r;
    case (f_r.st)
      jfpr_pkg::FT_IDLE: f_nxt.st = jfpr_pkg::FT_IDLE;
      jfpr_pkg::FT_WAIT: f_nxt.st = jfpr_pkg::FT_LATCH;
      jfpr_pkg::FT_LATCH: begin
        // ack mirrors the request seen, so a fetch restarted midway still pairs up
        f_nxt.word = flashRdData;
        f_nxt.ack = f_r.reqSeen;
        f_nxt.st = jfpr_pkg::FT_IDLE;
      end
      default: f_nxt.st = jfpr_pkg::FT_IDLE;
    endcase
    if (addrLoad) begin
      f_nxt.addr = addrPreset;
      f_nxt.st = jfpr_pkg::FT_WAIT;
    end else if (reqSync != f_r.reqSeen) begin
      f_nxt.reqSeen = reqSync;
      f_nxt.addr = f_r.addr + ADDR_W'(1);
      f_nxt.st = jfpr_pkg::FT_WAIT;
    end
    if (!ce) begin
      f_nxt = f_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_r <= '{st: jfpr_pkg::FT_WAIT, addr: '0, word: 16'h0000, ack: 1'b0, reqSeen: 1'b0};
    end else begin
      f_r <= f_nxt;
    end
  end

  assign lnk.ackTgl = f_r.ack;
  assign lnk.word = f_r.word;
  assign flashAddr = f_r.addr;
endmodule // jfpr_word_fetch

// ### hdl/jfpr_top.sv
module jfpr_top #(
  parameter int ADDR_W = jfpr_pkg::ADDR_W_DEF,
  parameter int TIMEOUT_A = jfpr_pkg::TIMEOUT_A_CYC,
  parameter int TIMEOUT_B = jfpr_pkg::TIMEOUT_B_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEn,
  input wire logic extRst_n,
  input wire logic [1:0] fuseStartup,
  input wire logic addrLoad,
  input wire logic [ADDR_W-1:0] addrPreset,
  output logic [ADDR_W-1:0] flashAddr,
  input wire logic [15:0] flashRdData,
  output logic chipRst,
  output logic progEnabled
);
  if (TIMEOUT_A < 1 || TIMEOUT_B < 1) begin : g_bad_timeout
    $error("jfpr_top: time-out counts must be at least 1");
  end
  if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr
    $error("jfpr_top: ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release, one copy per domain

  logic [1:0] sysRstSync_r;
  logic [1:0] tckRstSync_r;
  logic sysRst_n;
  logic tckRst_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sysRstSync_r <= 2'h0;
    end else begin
      sysRstSync_r <= {sysRstSync_r[0], 1'b1};
    end
  end

  always_ff @(posedge tck or negedge nrst) begin
    if (!nrst) begin
      tckRstSync_r <= 2'h0;
    end else begin
      tckRstSync_r <= {tckRstSync_r[0], 1'b1};
    end
  end

  assign sysRst_n = sysRstSync_r[1];
  assign tckRst_n = tckRstSync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // test clock domain: tap controller and data registers

  typedef struct packed {
    jfpr_pkg::jfpr_tap_t tap;
    logic [3:0] ir;
    logic [3:0] irSh;
    logic [14:0] cmd;
    logic [15:0] enSh;
    logic [15:0] enReg;
    logic unlocked;
    logic rstBit;
    logic bypass;
    logic hiNext;
    logic reqTgl;
    logic tdo;
    logic tdoEn;
  } jfpr_tck_t;

  jfpr_tck_t t_r;
  jfpr_tck_t t_nxt;
  jfpr_fetch_if fetchLink ();
  logic ackSync;
  logic progMode;
  logic wordReady;
  logic ceTck;

  function automatic jfpr_pkg::jfpr_tap_t tapNext(input jfpr_pkg::jfpr_tap_t s,
                                                   input logic m);
    jfpr_pkg::jfpr_tap_t r;
    r = jfpr_pkg::TAP_RESET;
    case (s)
      jfpr_pkg::TAP_RESET: r = m ? jfpr_pkg::TAP_RESET : jfpr_pkg::TAP_IDLE;
      jfpr_pkg::TAP_IDLE: r = m ? jfpr_pkg::TAP_SEL_DR : jfpr_pkg::TAP_IDLE;
      jfpr_pkg::TAP_SEL_DR: r = m ? jfpr_pkg::TAP_SEL_IR : jfpr_pkg::TAP_CAP_DR;
      jfpr_pkg::TAP_CAP_DR: r = m ? jfpr_pkg::TAP_EXIT1_DR : jfpr_pkg::TAP_SHIFT_DR;
      jfpr_pkg::TAP_SHIFT_DR: r = m ? jfpr_pkg::TAP_EXIT1_DR : jfpr_pkg::TAP_SHIFT_DR;
      jfpr_pkg::TAP_EXIT1_DR: r = m ? jfpr_pkg::TAP_UPD_DR : jfpr_pkg::TAP_PAUSE_DR;
      jfpr_pkg::TAP_PAUSE_DR: r = m ? jfpr_pkg::TAP_EXIT2_DR : jfpr_pkg::TAP_PAUSE_DR;
      jfpr_pkg::TAP_EXIT2_DR: r = m ? jfpr_pkg::TAP_UPD_DR : jfpr_pkg::TAP_SHIFT_DR;
      jfpr_pkg::TAP_UPD_DR: r = m ? jfpr_pkg::TAP_SEL_DR : jfpr_pkg::TAP_IDLE;
      jfpr_pkg::TAP_SEL_IR: r = m ? jfpr_pkg::TAP_RESET : jfpr_pkg::TAP_CAP_IR;
      jfpr_pkg::TAP_CAP_IR: r = m ? jfpr_pkg::TAP_EXIT1_IR : jfpr_pkg::TAP_SHIFT_IR;
      jfpr_pkg::TAP_SHIFT_IR: r = m ? jfpr_pkg::TAP_EXIT1_IR : jfpr_pkg::TAP_SHIFT_IR;
      jfpr_pkg::TAP_EXIT1_IR: r = m ? jfpr_pkg::TAP_UPD_IR : jfpr_pkg::TAP_PAUSE_IR;
      jfpr_pkg::TAP_PAUSE_IR: r = m ? jfpr_pkg::TAP_EXIT2_IR : jfpr_pkg::TAP_PAUSE_IR;
      jfpr_pkg::TAP_EXIT2_IR: r = m ? jfpr_pkg::TAP_UPD_IR : jfpr_pkg::TAP_SHIFT_IR;
      jfpr_pkg::TAP_UPD_IR: r = m ? jfpr_pkg::TAP_SEL_DR : jfpr_pkg::TAP_IDLE;
      default: r = jfpr_pkg::TAP_RESET;
    endcase
    return r;
  endfunction

  // ack comes back on the system clock, so it is synchronised before use
  jfpr_sync2 #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk(tck),
    .rst_n(tckRst_n),
    .ce(1'b1),
    .d(fetchLink.ackTgl),
    .q(ackSync)
  );

  // ce lives on the system clock; the test clock sees a synchronised copy
  jfpr_sync2 #(.W(1), .RST_VAL(1'b1)) u_ce_sync (
    .clk(tck),
    .rst_n(tckRst_n),
    .ce(1'b1),
    .d(ce),
    .q(ceTck)
  );

  assign progMode = t_r.unlocked;
  // word is only sampled while the handshake says it is stable
  assign wordReady = (ackSync == t_r.reqTgl);
  assign fetchLink.reqTgl = t_r.reqTgl;

  always_comb begin
    t_nxt = t_r;
    t_nxt.tap = tapNext(t_r.tap, tms);
    case (t_r.tap)
      jfpr_pkg::TAP_RESET: begin
        t_nxt.ir = jfpr_pkg::BYPASS_INSTR;
        t_nxt.hiNext = 1'b0;
      end
      jfpr_pkg::TAP_CAP_IR: t_nxt.irSh = jfpr_pkg::IR_CAPTURE_VAL;
      jfpr_pkg::TAP_SHIFT_IR: t_nxt.irSh = {tdi, t_r.irSh[3:1]};
      jfpr_pkg::TAP_UPD_IR: begin
        t_nxt.ir = t_r.irSh;
        t_nxt.hiNext = 1'b0;
      end
      jfpr_pkg::TAP_CAP_DR: begin
        case (t_r.ir)
          jfpr_pkg::DIRECT_FLASH_BYTE_CAPTURE_INSTR: begin
            if (!progMode) begin
              t_nxt.cmd[7:0] = jfpr_pkg::BLOCKED_BYTE;
            end else begin
              if (!wordReady) begin
                t_nxt.cmd[7:0] = jfpr_pkg::NOT_READY_BYTE;
              end else if (t_r.hiNext) begin
                t_nxt.cmd[7:0] = fetchLink.word[15:8];
              end else begin
                t_nxt.cmd[7:0] = fetchLink.word[7:0];
              end
              if (t_r.hiNext) begin
                t_nxt.reqTgl = ~t_r.reqTgl;
              end
              t_nxt.hiNext = ~t_r.hiNext;
            end
          end
          jfpr_pkg::PROGRAMMING_UNLOCK_SELECT: t_nxt.enSh = t_r.enSh;
          jfpr_pkg::RESET_REG_SELECT: t_nxt.rstBit = t_r.rstBit;
          default: t_nxt.bypass = 1'b0;
        endcase
      end
      jfpr_pkg::TAP_SHIFT_DR: begin
        case (t_r.ir)
          jfpr_pkg::DIRECT_FLASH_BYTE_CAPTURE_INSTR: begin
            t_nxt.cmd[7:0] = {tdi, t_r.cmd[7:1]};
          end
          jfpr_pkg::PROGRAMMING_UNLOCK_SELECT: begin
            t_nxt.enSh = {tdi, t_r.enSh[15:1]};
          end
          // no update stage: the shifted bit drives reset at once
          jfpr_pkg::RESET_REG_SELECT: t_nxt.rstBit = tdi;
          default: t_nxt.bypass = tdi;
        endcase
      end
      jfpr_pkg::TAP_UPD_DR: begin
        if (t_r.ir == jfpr_pkg::PROGRAMMING_UNLOCK_SELECT) begin
          t_nxt.enReg = t_r.enSh;
        end
      end
      default: t_nxt.tap = t_nxt.tap;
    endcase
    // tdo leads with the bit that the next shift edge moves out
    case (t_nxt.tap)
      jfpr_pkg::TAP_SHIFT_IR: t_nxt.tdo = t_nxt.irSh[0];
      jfpr_pkg::TAP_SHIFT_DR: begin
        case (t_r.ir)
          jfpr_pkg::DIRECT_FLASH_BYTE_CAPTURE_INSTR: t_nxt.tdo = t_nxt.cmd[0];
          jfpr_pkg::PROGRAMMING_UNLOCK_SELECT: t_nxt.tdo = t_nxt.enSh[0];
          jfpr_pkg::RESET_REG_SELECT: t_nxt.tdo = t_nxt.rstBit;
          default: t_nxt.tdo = t_nxt.bypass;
        endcase
      end
      default: t_nxt.tdo = 1'b0;
    endcase
    t_nxt.tdoEn = (t_nxt.tap == jfpr_pkg::TAP_SHIFT_IR) ||
                  (t_nxt.tap == jfpr_pkg::TAP_SHIFT_DR);
    // compare result registered, so the crossing never samples a compare glitch
    t_nxt.unlocked = (t_nxt.enReg == jfpr_pkg::UNLOCK_SIGNATURE);
    if (!ceTck) begin
      t_nxt = t_r;
    end
  end

  always_ff @(posedge tck or negedge tckRst_n) begin
    if (!tckRst_n) begin
      t_r <= '{
        tap: jfpr_pkg::TAP_RESET,
        ir: jfpr_pkg::BYPASS_INSTR,
        irSh: 4'h0,
        cmd: 15'h0000,
        enSh: 16'h0000,
        enReg: jfpr_pkg::ENABLE_RST_VAL,
        unlocked: 1'b0,
        rstBit: 1'b0,
        bypass: 1'b0,
        hiNext: 1'b0,
        reqTgl: 1'b0,
        tdo: 1'b0,
        tdoEn: 1'b0
      };
    end else begin
      t_r <= t_nxt;
    end
  end

  assign tdo = t_r.tdo;
  assign tdoEn = t_r.tdoEn;

  ////////////////////////////////////////////////////////////////////////////
  // system clock domain: flash word fetch and part reset

  jfpr_word_fetch #(.ADDR_W(ADDR_W)) u_fetch (
    .clk(clk_sys),
    .rst_n(sysRst_n),
    .ce(ce),
    .lnk(fetchLink),
    .addrLoad(addrLoad),
    .addrPreset(addrPreset),
    .flashAddr(flashAddr),
    .flashRdData(flashRdData)
  );

  logic [2:0] sysSync;
  logic [1:0] fuseSync;

  // pin reset, reset register and unlock flag, all levels
  jfpr_sync2 #(.W(3), .RST_VAL(1'b0)) u_sys_sync (
    .clk(clk_sys),
    .rst_n(sysRst_n),
    .ce(ce),
    .d({~extRst_n, t_r.rstBit, progMode}),
    .q(sysSync)
  );

  // fuse levels come from outside this clock as well
  jfpr_sync2 #(.W(2), .RST_VAL(1'b0)) u_fuse_sync (
    .clk(clk_sys),
    .rst_n(sysRst_n),
    .ce(ce),
    .d(fuseStartup),
    .q(fuseSync)
  );

  typedef struct packed {
    logic [31:0] cnt;
    logic chipRst;
    logic progEn;
  } jfpr_sys_t;

  jfpr_sys_t s_r;
  jfpr_sys_t s_nxt;

  function automatic logic [31:0] timeoutSel(input logic [1:0] sel);
    logic [31:0] r;
    r = jfpr_pkg::TIMEOUT_MIN_CYC;
    case (sel)
      2'h0: r = jfpr_pkg::TIMEOUT_MIN_CYC;
      2'h1: r = 32'(TIMEOUT_A);
      default: r = 32'(TIMEOUT_B);
    endcase
    return r;
  endfunction

  always_comb begin
    s_nxt = s_r;
    if (ce) begin
      s_nxt.progEn = sysSync[0];
      if (sysSync[2] || sysSync[1]) begin
        // same path as the pin: reset held as long as either asks
        s_nxt.cnt = timeoutSel(fuseSync);
        s_nxt.chipRst = 1'b1;
      end else if (s_r.cnt != 32'h0000_0000) begin
        s_nxt.cnt = s_r.cnt - 32'h0000_0001;
        s_nxt.chipRst = 1'b1;
      end else begin
        s_nxt.chipRst = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge sysRst_n) begin
    if (!sysRst_n) begin
      s_r <= '{
        cnt: 32'h0000_0000,
        chipRst: 1'b1,
        progEn: 1'b0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  assign chipRst = s_r.chipRst;
  assign progEnabled = s_r.progEn;
endmodule // jfpr_top

// ### tb/jfpr_top_assertions.sv
module jfpr_top_chk #(
  parameter int ADDR_W = jfpr_pkg::ADDR_W_DEF,
  parameter int TIMEOUT_A = jfpr_pkg::TIMEOUT_A_CYC,
  parameter int TIMEOUT_B = jfpr_pkg::TIMEOUT_B_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdoEn,
  input wire logic extRst_n,
  input wire logic [1:0] fuseStartup,
  input wire logic addrLoad,
  input wire logic [ADDR_W-1:0] addrPreset,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [15:0] flashRdData,
  input wire logic chipRst,
  input wire logic progEnabled
);
  timeunit 1ns;
  timeprecision 100ps;
  property p_ext_fast;
    @(posedge clk_sys) disable iff (!nrst) $fell(extRst_n) |-> ##[2:4] chipRst;
  endproperty
  a_ext_fast: assert property (p_ext_fast) else $error("pin reset not applied");
  property p_tmo_min;
    @(posedge clk_sys) disable iff (!nrst) $rose(extRst_n) && fuseStartup == 2'h1 |-> chipRst [*8];
  endproperty
  a_tmo_min: assert property (p_tmo_min) else $error("time-out cut short");
  property p_tmo_end;
    @(posedge clk_sys) disable iff (!nrst) $rose(extRst_n) |-> ##[1:60] !chipRst;
  endproperty
  a_tmo_end: assert property (p_tmo_end) else $error("time-out never ends");
  property p_load;
    @(posedge clk_sys) disable iff (!nrst) addrLoad && ce |=> flashAddr == $past(addrPreset);
  endproperty
  a_load: assert property (p_load) else $error("preset not loaded");
  // only a load may move the address by other than one
  property p_step;
    @(posedge clk_sys) disable iff (!nrst)
      !$stable(flashAddr) && !$past(addrLoad) |-> flashAddr == $past(flashAddr) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("address jump");
  property p_locked;
    @(posedge clk_sys) disable iff (!nrst)
      (!progEnabled) [*8] ##0 !$past(addrLoad) |-> $stable(flashAddr);
  endproperty
  a_locked: assert property (p_locked) else $error("address moved while locked");
  property p_prog_rst;
    @(posedge clk_sys) disable iff (!nrst) $rose(nrst) |-> (!progEnabled) [*3];
  endproperty
  a_prog_rst: assert property (p_prog_rst) else $error("enabled after reset");
  property p_tdo_idle;
    @(posedge tck) disable iff (!nrst) !tdoEn |-> !tdo;
  endproperty
  a_tdo_idle: assert property (p_tdo_idle) else $error("tdo active outside shift");
  property p_shift_hold;
    @(posedge tck) disable iff (!nrst) tdoEn |=> tdoEn == !$past(tms);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift state wrong");
endmodule // jfpr_top_chk
////////////////////////////////////////////////////////////////
bind jfpr_top jfpr_top_chk #(.ADDR_W(ADDR_W), .TIMEOUT_A(TIMEOUT_A), .TIMEOUT_B(TIMEOUT_B))
  u_jfpr_top_chk (.*);

// ### tb/jfpr_prog_model.sv
module jfpr_prog_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tck rests low between frames; idle tdi flips so stale bits never match
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #6;
    o = tdo;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask
  task automatic go_reset();
    logic o;
    repeat (5) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
  // from idle: two idle rises give the fetch ack time to cross
  task automatic scan(input logic ir, input int n, input logic [15:0] d, output logic [15:0] q);
    logic o;
    q = 16'h0000;
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b1, ~tdi, o);
    if (ir) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
  task automatic enter_prog(input logic [15:0] sig);
    logic [15:0] q;
    scan(1'b1, 4, 16'(jfpr_pkg::RESET_REG_SELECT), q);
    scan(1'b0, 1, 16'h0001, q);
    scan(1'b1, 4, 16'(jfpr_pkg::PROGRAMMING_UNLOCK_SELECT), q);
    scan(1'b0, 16, sig, q);
  endtask
  task automatic leave_prog();
    logic [15:0] q;
    scan(1'b1, 4, 16'(jfpr_pkg::PROGRAMMING_UNLOCK_SELECT), q);
    scan(1'b0, 16, 16'h0000, q);
    scan(1'b1, 4, 16'(jfpr_pkg::RESET_REG_SELECT), q);
    scan(1'b0, 1, 16'h0000, q);
  endtask
endmodule // jfpr_prog_model

// ### tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TA = 20;
  localparam int TB = 40;
  localparam int AW = jfpr_pkg::ADDR_W_DEF;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic extRst_n = 1'b1;
  logic [1:0] fuseStartup = 2'h0;
  logic addrLoad = 1'b0;
  logic [AW-1:0] addrPreset = '0;
  logic [15:0] flashRdData = 16'h0000;
  logic tck, tms, tdi, tdo, tdoEn, chipRst, progEnabled;
  logic [AW-1:0] flashAddr;
  logic [15:0] mem [64];
  logic [15:0] q;
  logic o;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int expAddr = 0;
  int ph = 0;
  int n;
  jfpr_top #(.TIMEOUT_A(TA), .TIMEOUT_B(TB)) u_jfpr_top (.*);
  jfpr_prog_model u_jfpr_prog_model (.*);
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi, input string what);
    checked++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("Error %0t: %s %0d outside %0d..%0d", $time, what, v, lo, hi);
    end
  endtask
  task automatic complete_run();
    $display("counts: %0d checked, %0d miscompares", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic clks(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic hold_count(output int k);
    k = 0;
    // looked at on the falling edge, where chipRst has settled
    while (chipRst === 1'b1 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  // behavioural reader: low then high byte, address steps after high
  task automatic capture(input int k);
    logic [7:0] e;
    for (int i = 0; i < k; i++) begin
      e = ph ? mem[expAddr % 64][15:8] : mem[expAddr % 64][7:0];
      u_jfpr_prog_model.scan(1'b0, 8, 16'($urandom), q);
      clks(10);
      if (ph == 1) expAddr++;
      ph = 1 - ph;
      chk(q[7:0], e, "flash byte");
      chk(16'(flashAddr), 16'(expAddr % (1 << AW)), "word address");
    end
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    flashRdData <= mem[flashAddr[5:0]];
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(75));
    foreach (mem[i]) mem[i] = 16'($urandom);
    u_jfpr_prog_model.go_reset();
    clks(3);
    nrst <= 1'b1;
    u_jfpr_prog_model.go_reset();
    clks(6);
    chk(progEnabled, 1'b0, "enable after reset");
    u_jfpr_prog_model.scan(1'b1, 4, 16'(jfpr_pkg::DIRECT_FLASH_BYTE_CAPTURE_INSTR), q);
    u_jfpr_prog_model.scan(1'b0, 16, 16'h005A, q);
    chk(q, {8'h5A, jfpr_pkg::BLOCKED_BYTE}, "locked read");
    chk(16'(flashAddr), 16'h0000, "locked address");
    $display("test locked read done");
    // stop tck inside shift: the bit alone must hold reset
    u_jfpr_prog_model.scan(1'b1, 4, 16'(jfpr_pkg::RESET_REG_SELECT), q);
    u_jfpr_prog_model.step(1'b1, 1'b0, o);
    u_jfpr_prog_model.step(1'b0, 1'b0, o);
    u_jfpr_prog_model.step(1'b0, 1'b0, o);
    u_jfpr_prog_model.step(1'b0, 1'b1, o);
    clks(8);
    chk(chipRst, 1'b1, "reset bit in shift");
    u_jfpr_prog_model.step(1'b1, 1'b1, o);
    u_jfpr_prog_model.step(1'b1, 1'b0, o);
    u_jfpr_prog_model.step(1'b0, 1'b0, o);
    $display("test reset bit done");
    u_jfpr_prog_model.enter_prog(jfpr_pkg::UNLOCK_SIGNATURE ^ (16'h0001 << ($urandom % 16)));
    clks(6);
    chk(progEnabled, 1'b0, "bad signature");
    u_jfpr_prog_model.enter_prog(jfpr_pkg::UNLOCK_SIGNATURE);
    clks(6);
    chk(progEnabled, 1'b1, "good signature");
    chk(chipRst, 1'b1, "reset held");
    $display("test unlock done");
    @(posedge clk_sys);
    addrPreset <= AW'($urandom);
    addrLoad <= 1'b1;
    @(posedge clk_sys);
    addrLoad <= 1'b0;
    clks(8);
    expAddr = int'(addrPreset);
    u_jfpr_prog_model.scan(1'b1, 4, 16'(jfpr_pkg::DIRECT_FLASH_BYTE_CAPTURE_INSTR), q);
    capture(5);
    // re-entering the instruction restarts at the low byte
    u_jfpr_prog_model.scan(1'b1, 4, 16'(jfpr_pkg::DIRECT_FLASH_BYTE_CAPTURE_INSTR), q);
    ph = 0;
    capture(4);
    $display("test page read done");
    @(posedge clk_sys);
    fuseStartup <= 2'h1;
    u_jfpr_prog_model.leave_prog();
    hold_count(n);
    chk_rng(n, TA - 2, TA + 6, "bit time-out");
    chk(progEnabled, 1'b0, "enable cleared");
    $display("test leave done");
    for (int f = 0; f < 4; f++) begin
      @(posedge clk_sys);
      fuseStartup <= 2'(f);
      extRst_n <= 1'b0;
      clks(6);
      chk(chipRst, 1'b1, "pin reset");
      extRst_n <= 1'b1;
      hold_count(n);
      n = n - 1;
      chk_rng(n, f == 0 ? 1 : (f == 1 ? TA : TB), (f == 0 ? 1 : (f == 1 ? TA : TB)) + 6,
        "pin time-out");
      clks(4);
    end
    $display("test pin reset done");
    // clock enable low: a load pulse must leave the address alone
    @(posedge clk_sys);
    ce <= 1'b0;
    addrPreset <= ~flashAddr;
    addrLoad <= 1'b1;
    @(posedge clk_sys);
    addrLoad <= 1'b0;
    clks(4);
    chk(16'(flashAddr), 16'(expAddr % (1 << AW)), "address with ce low");
    ce <= 1'b1;
    $display("test clock enable done");
    complete_run();
  end
endmodule // tb_top
